// *** level_based_interrupt_collector.sv ***
// level based interrupt collector with periodic timer and pin config
`timescale 1ns/10ps
// Notes on behaviour
// - pins 3..6 have fixed levels 6,8,10,12; others programmable 0..31
// - a source request sets the pending bit of its level
// - enable vector, one bit per level, gates each level
// - masked vector reads as pending AND enables
// - single request to core while any masked bit is set
// - no hardware priority; software orders levels, level 0 highest
// - each pin has a 2-bit usage field
// - each pin has a 2-bit sensitivity field
// - core-direct pins bypass pending, levels and enables
// - 5-bit level fields for timer and pins 0..2
// - enabled timer counts down 16 bits, requests on passing zero
// - timer reloads programmed count after each time-out
// - timer control holds clock select, reload, enables and status
// - reset leaves all interrupt generation disabled
// - vector bit 0 is msb, so level 0 sits at bit 31
module level_based_interrupt_collector (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdData,
  // request pins, active low, usable as general purpose io
  input  wire logic [6:0]  extRequestPinIn,
  output logic      [6:0]  extRequestPinOut,
  output logic      [6:0]  extRequestPinOe,
  // toward the processor core
  output logic             controllerIrq,
  output logic             coreDirectIrq
);

  localparam int NP = irq_collector_pkg::NUM_PINS;
  localparam int NL = irq_collector_pkg::NUM_LEVELS;

  logic [31:0]   levelEnables_reg;
  logic [31:0]   pinAssign_reg;
  logic [19:0]   sourceLevel_reg;
  logic [15:0]   count_reg;
  logic [15:0]   reload_reg;
  logic [1:0]    clkSel_reg;
  logic          cntEn_reg;
  logic          timerIrqEn_reg;
  logic          timerStatus_reg;
  logic [7:0]    prescale_reg;
  logic [6:0]    pinDataOut_reg;
  logic [NP-1:0] sync1_reg;
  logic [NP-1:0] sync2_reg;
  logic [NP-1:0] sync3_reg;
  logic [NP-1:0] pinState_reg;
  logic [NP-1:0] edgeLatch_reg;
  logic [31:0]   pending;
  logic [31:0]   masked;
  logic [NP-1:0] pinActive;
  logic [NP-1:0] pinEvent;
  logic [NP-1:0] pinToCtl;
  logic [NP-1:0] pinDirect;
  logic [4:0]    pinLevel [NP];
  logic [4:0]    timerLevel;
  logic [7:0]    prescaleDiv;
  logic          tick;
  logic          timeout;
  logic          wrHit;
  logic          rdHit;

  assign wrHit = regWrite;
  assign rdHit = regRead;

  //////////////////////////////////////////////////////////////////////////
  // pin input synchronisers: change counts once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      sync3_reg <= '1;
    end else begin
      sync1_reg <= extRequestPinIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinState_reg <= '1;
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          pinState_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per pin decode of usage, sensitivity and level
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : gPin
      logic [1:0] usage;
      logic [1:0] sense;
      logic       filtered;
      assign usage = pinAssign_reg[g*irq_collector_pkg::PIN_FIELD_STRIDE +: 2];
      assign sense = pinAssign_reg[g*irq_collector_pkg::PIN_FIELD_STRIDE
                     + irq_collector_pkg::PIN_SENSE_POS +: 2];
      // next debounced value; equal to the held one when no change is seen
      assign filtered = (sync2_reg[g] == sync3_reg[g]) ? sync3_reg[g]
                                                       : pinState_reg[g];
      // pins are active low: low level or the chosen edge is a request
      always_comb begin
        pinActive[g] = 1'b0;
        pinEvent[g] = 1'b0;
        case (sense)
          irq_collector_pkg::SENSE_LEVEL: pinActive[g] = !pinState_reg[g];
          irq_collector_pkg::SENSE_FALL:
            pinEvent[g] = pinState_reg[g] && !filtered;
          irq_collector_pkg::SENSE_RISE:
            pinEvent[g] = !pinState_reg[g] && filtered;
          irq_collector_pkg::SENSE_BOTH:
            pinEvent[g] = pinState_reg[g] != filtered;
          default: pinActive[g] = 1'b0;
        endcase
      end
      assign pinToCtl[g] = usage == irq_collector_pkg::USE_CONTROLLER;
      assign pinDirect[g] = (usage == irq_collector_pkg::USE_CORE_DIRECT)
                            && (sense == irq_collector_pkg::SENSE_LEVEL
                                ? !pinState_reg[g] : edgeLatch_reg[g]);
      if (g < 3) begin : gProg
        assign pinLevel[g] =
          sourceLevel_reg[g*irq_collector_pkg::LEVEL_FIELD_WIDTH +: 5];
      end else begin : gFixed
        assign pinLevel[g] = (g == 3) ? irq_collector_pkg::LEVEL_PIN3 :
                             (g == 4) ? irq_collector_pkg::LEVEL_PIN4 :
                             (g == 5) ? irq_collector_pkg::LEVEL_PIN5 :
                                        irq_collector_pkg::LEVEL_PIN6;
      end
    end
  endgenerate

  assign timerLevel =
    sourceLevel_reg[irq_collector_pkg::TIMER_LEVEL_POS +: 5];

  //////////////////////////////////////////////////////////////////////////
  // edge latches: set wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      edgeLatch_reg <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (pinEvent[i]) begin
          edgeLatch_reg[i] <= 1'b1;
        end else if (wrHit && regAddr == irq_collector_pkg::ADDR_EDGE_CLEAR
                     && regWrData[i]) begin
          edgeLatch_reg[i] <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pending vector, level n at bit 31-n
  always_comb begin
    pending = '0;
    for (int i = 0; i < NP; i++) begin
      if (pinToCtl[i] && (pinActive[i] || edgeLatch_reg[i])) begin
        pending[5'd31 - pinLevel[i]] = 1'b1;
      end
    end
    if (timerStatus_reg && timerIrqEn_reg) begin
      pending[5'd31 - timerLevel] = 1'b1;
    end
  end

  assign masked = pending & levelEnables_reg;

  //////////////////////////////////////////////////////////////////////////
  // configuration registers cleared, pin output data set to ones, so nothing requests after reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      levelEnables_reg <= irq_collector_pkg::RESET_ZERO;
      pinAssign_reg <= irq_collector_pkg::RESET_ZERO;
      sourceLevel_reg <= '0;
      reload_reg <= '0;
      clkSel_reg <= '0;
      cntEn_reg <= 1'b0;
      timerIrqEn_reg <= 1'b0;
      pinDataOut_reg <= '1;
    end else if (wrHit) begin
      case (regAddr)
        irq_collector_pkg::ADDR_LEVEL_ENABLES: levelEnables_reg <= regWrData;
        irq_collector_pkg::ADDR_PIN_ASSIGNMENT: pinAssign_reg <= regWrData;
        irq_collector_pkg::ADDR_SOURCE_LEVEL: sourceLevel_reg <= regWrData[19:0];
        irq_collector_pkg::ADDR_PIN_DATA: pinDataOut_reg <= regWrData[6:0];
        irq_collector_pkg::ADDR_TIMER_CONTROL: begin
          reload_reg <= regWrData[irq_collector_pkg::TCTL_RELOAD_POS +: 16];
          clkSel_reg <= regWrData[irq_collector_pkg::TCTL_CLK_SEL_POS +: 2];
          cntEn_reg <= regWrData[irq_collector_pkg::TCTL_CNT_EN_POS];
          timerIrqEn_reg <= regWrData[irq_collector_pkg::TCTL_IRQ_EN_POS];
        end
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // timer prescaler: one-cycle tick at the selected rate
  always_comb begin
    case (clkSel_reg)
      2'h0: prescaleDiv = irq_collector_pkg::PRESCALE_DIV0;
      2'h1: prescaleDiv = irq_collector_pkg::PRESCALE_DIV1;
      2'h2: prescaleDiv = irq_collector_pkg::PRESCALE_DIV2;
      default: prescaleDiv = irq_collector_pkg::PRESCALE_DIV3;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prescale_reg <= '0;
    end else if (!cntEn_reg || tick) begin
      prescale_reg <= '0;
    end else begin
      prescale_reg <= prescale_reg + 8'h01;
    end
  end

  assign tick = cntEn_reg && (prescale_reg == prescaleDiv - 8'h01);
  assign timeout = tick && (count_reg == 16'h0000);

  // count may also be written directly; a write loses to a tick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
    end else if (tick) begin
      if (timeout) begin
        count_reg <= reload_reg;
      end else begin
        count_reg <= count_reg - 16'h0001;
      end
    end else if (wrHit && regAddr == irq_collector_pkg::ADDR_PERIODIC_COUNT) begin
      count_reg <= regWrData[15:0];
    end
  end

  // status sticky; writing one clears it unless a time-out lands now
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timerStatus_reg <= 1'b0;
    end else if (timeout) begin
      timerStatus_reg <= 1'b1;
    end else if (wrHit && regAddr == irq_collector_pkg::ADDR_TIMER_CONTROL
                 && regWrData[irq_collector_pkg::TCTL_STATUS_POS]) begin
      timerStatus_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read port, data in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdData <= '0;
    end else if (rdHit) begin
      case (regAddr)
        irq_collector_pkg::ADDR_PENDING_LEVELS: regRdData <= pending;
        irq_collector_pkg::ADDR_LEVEL_ENABLES: regRdData <= levelEnables_reg;
        irq_collector_pkg::ADDR_MASKED_PENDING: regRdData <= masked;
        irq_collector_pkg::ADDR_PIN_ASSIGNMENT: regRdData <= pinAssign_reg;
        irq_collector_pkg::ADDR_SOURCE_LEVEL: regRdData <= {12'h000, sourceLevel_reg};
        irq_collector_pkg::ADDR_PERIODIC_COUNT: regRdData <= {16'h0000, count_reg};
        irq_collector_pkg::ADDR_TIMER_CONTROL:
          regRdData <= {reload_reg, 10'h000, clkSel_reg, 1'b0, cntEn_reg,
                        timerIrqEn_reg, timerStatus_reg};
        irq_collector_pkg::ADDR_EDGE_CLEAR: regRdData <= {25'h0, edgeLatch_reg};
        irq_collector_pkg::ADDR_PIN_DATA: regRdData <= {25'h0, pinState_reg};
        default: regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs; no priority is applied, software scans the masked vector
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      controllerIrq <= 1'b0;
      coreDirectIrq <= 1'b0;
      extRequestPinOut <= '1;
      extRequestPinOe <= '0;
    end else begin
      controllerIrq <= |masked;
      coreDirectIrq <= |pinDirect;
      extRequestPinOut <= pinDataOut_reg;
      for (int i = 0; i < NP; i++) begin
        extRequestPinOe[i] <= pinAssign_reg[i*irq_collector_pkg::PIN_FIELD_STRIDE
                              +: 2] == irq_collector_pkg::USE_GP_OUTPUT;
      end
    end
  end

endmodule // level_based_interrupt_collector

// *** irq_collector_pkg.sv ***
// constants for the level based interrupt collector
package irq_collector_pkg;
  localparam int NUM_PINS = 7;
  localparam int NUM_LEVELS = 32;
  // register byte addresses
  localparam logic [7:0] ADDR_PENDING_LEVELS = 8'h00;
  localparam logic [7:0] ADDR_LEVEL_ENABLES = 8'h04;
  localparam logic [7:0] ADDR_MASKED_PENDING = 8'h08;
  localparam logic [7:0] ADDR_PIN_ASSIGNMENT = 8'h0c;
  localparam logic [7:0] ADDR_SOURCE_LEVEL = 8'h10;
  localparam logic [7:0] ADDR_PERIODIC_COUNT = 8'h14;
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h18;
  localparam logic [7:0] ADDR_EDGE_CLEAR = 8'h1c;
  localparam logic [7:0] ADDR_PIN_DATA = 8'h20;
  // pin usage field encodings
  localparam logic [1:0] USE_GP_INPUT = 2'h0;
  localparam logic [1:0] USE_GP_OUTPUT = 2'h1;
  localparam logic [1:0] USE_CORE_DIRECT = 2'h2;
  localparam logic [1:0] USE_CONTROLLER = 2'h3;
  // pin sensitivity field encodings
  localparam logic [1:0] SENSE_LEVEL = 2'h0;
  localparam logic [1:0] SENSE_FALL = 2'h1;
  localparam logic [1:0] SENSE_RISE = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;
  // pin assignment layout: pin i usage at 4i, sensitivity at 4i+2
  localparam int PIN_FIELD_STRIDE = 4;
  localparam int PIN_SENSE_POS = 2;
  // source level layout: pins 0..2 at 5i, timer at 15
  localparam int LEVEL_FIELD_WIDTH = 5;
  localparam int TIMER_LEVEL_POS = 15;
  // fixed levels of pins 3..6
  localparam logic [4:0] LEVEL_PIN3 = 5'h06;
  localparam logic [4:0] LEVEL_PIN4 = 5'h08;
  localparam logic [4:0] LEVEL_PIN5 = 5'h0a;
  localparam logic [4:0] LEVEL_PIN6 = 5'h0c;
  // timer control layout
  localparam int TCTL_STATUS_POS = 0;
  localparam int TCTL_IRQ_EN_POS = 1;
  localparam int TCTL_CNT_EN_POS = 2;
  localparam int TCTL_CLK_SEL_POS = 4;
  localparam int TCTL_RELOAD_POS = 16;
  // timer prescale divides per clock select value
  localparam logic [7:0] PRESCALE_DIV0 = 8'h01;
  localparam logic [7:0] PRESCALE_DIV1 = 8'h04;
  localparam logic [7:0] PRESCALE_DIV2 = 8'h10;
  localparam logic [7:0] PRESCALE_DIV3 = 8'h80;
  // reset values
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage

// *** irq_collector_asserts.sv ***
// port checks for the level based interrupt collector
`timescale 1ns/10ps
module irq_collector_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdData,
  // pins and core requests
  input wire logic [6:0]  extRequestPinIn,
  input wire logic [6:0]  extRequestPinOut,
  input wire logic [6:0]  extRequestPinOe,
  input wire logic        controllerIrq,
  input wire logic        coreDirectIrq
);
  logic [6:0] oeWant;
  logic [6:0] outWant;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oeWant <= 7'h00;
    end else if (regWrite &&
                 regAddr == irq_collector_pkg::ADDR_PIN_ASSIGNMENT) begin
      for (int i = 0; i < 7; i++) begin
        oeWant[i] <= regWrData[4*i+:2] == irq_collector_pkg::USE_GP_OUTPUT;
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      outWant <= 7'h7f;
    end else if (regWrite && regAddr == irq_collector_pkg::ADDR_PIN_DATA) begin
      outWant <= regWrData[6:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);
  // write then read of the same place, one idle cycle between
  sequence s_wrRd(logic [7:0] a);
    regWrite && regAddr == a ##2 regRead && regAddr == a;
  endsequence
  sequence s_enOffRead;
    regWrite && regAddr == irq_collector_pkg::ADDR_LEVEL_ENABLES &&
      regWrData == 32'h0 ##2
      regRead && regAddr == irq_collector_pkg::ADDR_MASKED_PENDING;
  endsequence
  property p_resetQuiet;
    $rose(rstn) |-> !controllerIrq && !coreDirectIrq &&
      extRequestPinOe == 7'h00 && extRequestPinOut == 7'h7f;
  endproperty
  property p_maskedIrq;
    regRead && regAddr == irq_collector_pkg::ADDR_MASKED_PENDING |=>
      (regRdData != 32'h0) == controllerIrq;
  endproperty
  property p_maskZero;
    s_enOffRead |=> regRdData == 32'h0;
  endproperty
  property p_wrBack(logic [7:0] a, logic [31:0] m);
    s_wrRd(a) |=> ((regRdData ^ $past(regWrData, 3)) & m) == 32'h0;
  endproperty
  property p_usageOe;
    regWrite && regAddr == irq_collector_pkg::ADDR_PIN_ASSIGNMENT |->
      ##2 extRequestPinOe == oeWant;
  endproperty
  property p_gpOut;
    regWrite && regAddr == irq_collector_pkg::ADDR_PIN_DATA |->
      ##2 extRequestPinOut == outWant;
  endproperty
  a_resetQuiet: assert property (p_resetQuiet)
    else $error("outputs active right after reset");
  a_maskedIrq: assert property (p_maskedIrq)
    else $error("request output disagrees with masked view");
  a_maskZero: assert property (p_maskZero)
    else $error("masked view not empty with all levels off");
  a_enableRw: assert property (p_wrBack(
    irq_collector_pkg::ADDR_LEVEL_ENABLES, 32'hffff_ffff))
    else $error("enable vector read back differs");
  a_levelRw: assert property (p_wrBack(
    irq_collector_pkg::ADDR_SOURCE_LEVEL, 32'h000f_ffff))
    else $error("level fields read back differ");
  a_senseRw: assert property (p_wrBack(
    irq_collector_pkg::ADDR_PIN_ASSIGNMENT, 32'h0fff_ffff))
    else $error("pin fields read back differ");
  a_reloadRw: assert property (p_wrBack(
    irq_collector_pkg::ADDR_TIMER_CONTROL, 32'hffff_0000))
    else $error("reload value read back differs");
  a_usageOe: assert property (p_usageOe)
    else $error("output enables do not follow usage");
  a_gpOut: assert property (p_gpOut)
    else $error("pin output data not applied");
endmodule // irq_collector_asserts

// *** core_irq_model.sv ***
// processor core side: samples the two request levels
`timescale 1ns/10ps
module core_irq_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // requests from the collector
  input  wire logic controllerIrq,
  input  wire logic coreDirectIrq,
  // observed activity
  output int        ctlRises,
  output int        directRises
);
  logic ctlSeen;
  logic directSeen;
  // no acknowledge exists, so software must clear each source itself
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctlSeen     <= 1'b0;
      directSeen  <= 1'b0;
      ctlRises    <= 0;
      directRises <= 0;
    end else begin
      ctlSeen     <= controllerIrq;
      directSeen  <= coreDirectIrq;
      ctlRises    <= ctlRises + int'(controllerIrq && !ctlSeen);
      directRises <= directRises + int'(coreDirectIrq && !directSeen);
    end
  end
endmodule // core_irq_model

// *** level_based_interrupt_collector_test.sv ***
// self-checking bench for the level based interrupt collector
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin numErrors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module level_based_interrupt_collector_test;
  logic        clk;
  logic        rstn;
  logic [7:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdData;
  logic [6:0]  pinDrive;
  logic [6:0]  pinWire;
  logic [6:0]  pinOut;
  logic [6:0]  pinOe;
  logic        controllerIrq;
  logic        coreDirectIrq;
  logic [31:0] rd;
  logic [31:0] en;
  logic [31:0] expV;
  int          lvl [8];
  int          prev;
  int          ctlRises;
  int          directRises;
  int          numErrors;
  int          comparisons;
  // a pin set as output sees its own driven level
  assign pinWire = (pinOe & pinOut) | (~pinOe & pinDrive);
  level_based_interrupt_collector i_dut (
    .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .extRequestPinIn(pinWire), .extRequestPinOut(pinOut),
    .extRequestPinOe(pinOe), .controllerIrq(controllerIrq),
    .coreDirectIrq(coreDirectIrq));
  core_irq_model i_core (
    .clk(clk), .rstn(rstn), .controllerIrq(controllerIrq),
    .coreDirectIrq(coreDirectIrq), .ctlRises(ctlRises),
    .directRises(directRises));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] bitOf(int l);
    return 32'h1 << (31 - l);
  endfunction
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrite  <= wr;
    regRead   <= !wr;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regRead  <= 1'b0;
    @(negedge clk);
    rd = regRdData;
  endtask
  // pins pass a three stage synchroniser before any effect
  task automatic pin(input int i, input logic v);
    @(posedge clk);
    pinDrive[i] <= v;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    $display("watchdog expired");
    end_sim();
  end
  initial begin
    rstn = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    pinDrive = 7'h7f;
    numErrors = 0;
    comparisons = 0;
    void'($urandom(32'h9625f049));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 13; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      `CHK(rd, 32'h0)
    end
    bus(1'b0, 8'hfc, 32'h0);
    `CHK(rd, 32'h0)
    $display("reset test done");
    en = $urandom;
    bus(1'b1, irq_collector_pkg::ADDR_LEVEL_ENABLES, en);
    bus(1'b0, irq_collector_pkg::ADDR_LEVEL_ENABLES, 32'h0);
    `CHK(rd, en)
    bus(1'b1, irq_collector_pkg::ADDR_LEVEL_ENABLES, 32'h0);
    bus(1'b0, irq_collector_pkg::ADDR_MASKED_PENDING, 32'h0);
    `CHK(rd, 32'h0)
    // pin1 falling edge, pin2 straight to the core, the rest by level
    expV = 32'h0333_3333;
    expV[7:6] = irq_collector_pkg::SENSE_FALL;
    expV[9:8] = irq_collector_pkg::USE_CORE_DIRECT;
    bus(1'b1, irq_collector_pkg::ADDR_PIN_ASSIGNMENT, expV);
    bus(1'b0, irq_collector_pkg::ADDR_PIN_ASSIGNMENT, 32'h0);
    `CHK(rd & 32'h0fff_ffff, expV)
    foreach (lvl[i]) lvl[i] = (i > 2 && i < 7) ? 2 * i : $urandom_range(31);
    expV = {12'h0, 5'(lvl[7]), 5'(lvl[2]), 5'(lvl[1]), 5'(lvl[0])};
    bus(1'b1, irq_collector_pkg::ADDR_SOURCE_LEVEL, expV);
    bus(1'b0, irq_collector_pkg::ADDR_SOURCE_LEVEL, 32'h0);
    `CHK(rd & 32'h000f_ffff, expV)
    bus(1'b1, irq_collector_pkg::ADDR_LEVEL_ENABLES, 32'hffff_ffff);
    for (int i = 0; i < 7; i++) begin
      if (i == 1 || i == 2) continue;
      pin(i, 1'b0);
      bus(1'b0, irq_collector_pkg::ADDR_PENDING_LEVELS, 32'h0);
      `CHK(rd, bitOf(lvl[i]))
      `CHK(controllerIrq, 1'b1)
      pin(i, 1'b1);
      bus(1'b0, irq_collector_pkg::ADDR_PENDING_LEVELS, 32'h0);
      `CHK(rd, 32'h0)
    end
    $display("level pin test done");
    en = $urandom | bitOf(6);
    bus(1'b1, irq_collector_pkg::ADDR_LEVEL_ENABLES, en);
    @(posedge clk) pinDrive <= 7'h37;
    pin(3, 1'b0);
    bus(1'b0, irq_collector_pkg::ADDR_MASKED_PENDING, 32'h0);
    `CHK(rd, (bitOf(6) | bitOf(12)) & en)
    `CHK(rd[31:25], 7'h01)
    bus(1'b1, irq_collector_pkg::ADDR_LEVEL_ENABLES, ~(bitOf(6) | bitOf(12)));
    // the request output is registered: it drops one cycle after the write
    @(negedge clk);
    `CHK(controllerIrq, 1'b0)
    @(posedge clk) pinDrive <= 7'h7f;
    pin(1, 1'b0);
    pin(1, 1'b1);
    bus(1'b1, irq_collector_pkg::ADDR_LEVEL_ENABLES, 32'hffff_ffff);
    bus(1'b0, irq_collector_pkg::ADDR_PENDING_LEVELS, 32'h0);
    `CHK(rd, bitOf(lvl[1]))
    bus(1'b1, irq_collector_pkg::ADDR_EDGE_CLEAR, 32'h2);
    bus(1'b0, irq_collector_pkg::ADDR_PENDING_LEVELS, 32'h0);
    `CHK(rd, 32'h0)
    pin(2, 1'b0);
    `CHK(coreDirectIrq, 1'b1)
    bus(1'b0, irq_collector_pkg::ADDR_PENDING_LEVELS, 32'h0);
    `CHK(rd, 32'h0)
    pin(2, 1'b1);
    `CHK(directRises, 1)
    $display("edge and direct test done");
    // reload 5 gives a period of 6; reads land 2 cycles apart
    bus(1'b1, irq_collector_pkg::ADDR_PERIODIC_COUNT, 32'h5);
    bus(1'b1, irq_collector_pkg::ADDR_TIMER_CONTROL, 32'h0005_0006);
    bus(1'b0, irq_collector_pkg::ADDR_PERIODIC_COUNT, 32'h0);
    `CHK(rd[15:0], 16'h0004)
    prev = 4;
    repeat (8) begin
      prev = (prev + 4) % 6;
      bus(1'b0, irq_collector_pkg::ADDR_PERIODIC_COUNT, 32'h0);
      `CHK(rd[15:0], 16'(prev))
    end
    bus(1'b0, irq_collector_pkg::ADDR_TIMER_CONTROL, 32'h0);
    `CHK(rd[0], 1'b1)
    bus(1'b0, irq_collector_pkg::ADDR_PENDING_LEVELS, 32'h0);
    `CHK(rd, bitOf(lvl[7]))
    bus(1'b1, irq_collector_pkg::ADDR_TIMER_CONTROL, 32'h0005_0000);
    bus(1'b1, irq_collector_pkg::ADDR_TIMER_CONTROL, 32'h0005_0001);
    bus(1'b0, irq_collector_pkg::ADDR_TIMER_CONTROL, 32'h0);
    `CHK(rd, 32'h0005_0000)
    bus(1'b0, irq_collector_pkg::ADDR_PENDING_LEVELS, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b1, irq_collector_pkg::ADDR_PERIODIC_COUNT, 32'h2);
    bus(1'b1, irq_collector_pkg::ADDR_TIMER_CONTROL, 32'h0005_0014);
    // divide by 4: one tick every fourth cycle, reads two cycles apart
    for (int k = 1; k < 5; k++) begin
      bus(1'b0, irq_collector_pkg::ADDR_PERIODIC_COUNT, 32'h0);
      `CHK(rd[15:0], 16'(2 - (2 * k - 1) / 4))
    end
    $display("timer test done");
    bus(1'b1, irq_collector_pkg::ADDR_PIN_ASSIGNMENT, 32'h0111_1111);
    expV = $urandom;
    bus(1'b1, irq_collector_pkg::ADDR_PIN_DATA, expV);
    pin(0, 1'b1);
    `CHK(pinOe, 7'h7f)
    `CHK(pinOut, expV[6:0])
    bus(1'b0, irq_collector_pkg::ADDR_PIN_DATA, 32'h0);
    `CHK(rd[6:0], expV[6:0])
    `CHK(ctlRises > 0, 1'b1)
    $display("output test done");
    end_sim();
  end
endmodule // level_based_interrupt_collector_test
bind level_based_interrupt_collector irq_collector_asserts i_chk (
  .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .extRequestPinIn(extRequestPinIn), .extRequestPinOut(extRequestPinOut),
  .extRequestPinOe(extRequestPinOe), .controllerIrq(controllerIrq),
  .coreDirectIrq(coreDirectIrq));
